/* verilog/pil_regs.vh */
/*
 * Constants of the priority interrupt logic: register offsets,
 * field positions, reset values and pulse-time figures.
 * Assumes the includer runs on the single machine clock mclk.
 */
`ifndef PIL_REGS_VH
`define PIL_REGS_VH

// register offsets (byte addresses)
`define PIL_OFS_MASK 8'h00
`define PIL_OFS_PENDING 8'h04
`define PIL_OFS_INSERV 8'h08
`define PIL_OFS_EVT_STATUS 8'h0c
`define PIL_OFS_EVT_CLEAR 8'h10
`define PIL_OFS_EVT_ENABLE 8'h14
`define PIL_OFS_VECTOR 8'h18
`define PIL_OFS_FLAGS 8'h1c

// reset values
`define PIL_RST_MASK 32'hffffffff
`define PIL_RST_EVT_ENABLE 3'h0

// event status bit positions
`define PIL_EVT_REQ 0
`define PIL_EVT_ACK 1
`define PIL_EVT_EXIT 2
`define PIL_EVT_W 3

// flags register bit positions
`define PIL_FLG_INT 0
`define PIL_FLG_REQ 1

// pulse-time figures
`define PIL_T_WIN_HI 5'h16
`define PIL_T_WIN_LO 5'h11
`define PIL_T_FLAG 5'h0a
`define PIL_T_LOAD 5'h09

// opcode of the unconditional branch
`define PIL_OP_BRANCH 6'h01

// default vector of channel zero
`define PIL_VEC_BASE 10'h040

`endif

/* verilog/pil_top.v */
/*
 * Priority interrupt logic with its processor-side sequencing:
 * per-channel pending and in-service flip-flops, priority chain,
 * interrupt flag, vector load, acknowledge and subroutine exit.
 * Assumes pulse time, phase and opcode inputs come from the
 * processor sequencer on mclk; interrupt lines come from pins.
 */
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pil_regs.vh"

module pil_top #(
   parameter NGROUPS = 1,
   parameter [9:0] VEC_BASE = `PIL_VEC_BASE
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // external interrupt lines, channel 0 highest
   input wire [16*NGROUPS-1:0] int_line,
   // processor sequencing
   input wire [4:0] pulse_time,
   input wire phase_bit_one,
   input wire phase_zero,
   input wire indirect_bit,
   input wire [5:0] opcode,
   input wire skip_taken,
   input wire memory_share_cycle,
   input wire halt_flag,
   input wire parity_error_flag,
   input wire run_switch_gate,
   input wire stop_clear,
   // processor controls
   output reg request_to_processor,
   output reg interrupt_flag,
   output reg acknowledge_pulse,
   output reg subroutine_exit_pulse,
   output reg [9:0] vector_address_lines,
   output reg load_vector,
   output reg suppress_p_transfer,
   output reg halt_clear,
   output reg enter_increment_phase,
   // register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // interrupt
   output wire irq
);

   localparam NCH = 16 * NGROUPS;
   localparam IW = 6;

   // lowest set index wins; returns NCH when none is set
   function [IW-1:0] first_set;
      input [NCH-1:0] v;
      integer k;
      begin
         k = NCH;
         first_set = k[IW-1:0];
         for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (v[k])
               first_set = k[IW-1:0];
         end
      end
   endfunction

   // one-hot of a first_set result
   function [NCH-1:0] onehot;
      input [IW-1:0] idx;
      integer k;
      begin
         onehot = {NCH{1'b0}};
         for (k = 0; k < NCH; k = k + 1) begin
            if (idx == k[IW-1:0])
               onehot[k] = 1'b1;
         end
      end
   endfunction

   // line synchronisers
   reg [NCH-1:0] line_meta;
   reg [NCH-1:0] line_sync;

   // channel state
   reg [NCH-1:0] pending;
   reg [NCH-1:0] in_service;
   reg [NCH-1:0] next_pending;
   reg [NCH-1:0] next_in_service;

   // software registers
   reg [NCH-1:0] chan_mask;
   reg [`PIL_EVT_W-1:0] evt_status;
   reg [`PIL_EVT_W-1:0] evt_enable;
   reg [`PIL_EVT_W-1:0] next_evt_status;

   // decoded timing
   wire in_window;
   wire at_flag_time;
   wire at_load_time;
   wire end_cycle;

   // priority
   wire [IW-1:0] top_pending;
   wire [IW-1:0] top_service;
   wire [NCH-1:0] top_pending_hot;
   wire [NCH-1:0] top_service_hot;
   wire any_pending;
   wire any_service;
   wire next_request;
   wire exit_now;
   wire exit_first;
   wire ack_now;
   wire flag_set;
   wire flag_clear;
   reg req_prev;

   assign in_window = (pulse_time <= `PIL_T_WIN_HI) && (pulse_time >= `PIL_T_WIN_LO);
   assign at_flag_time = (pulse_time == `PIL_T_FLAG);
   assign at_load_time = (pulse_time == `PIL_T_LOAD);
   // phase bit one high marks an end cycle
   assign end_cycle = phase_bit_one;

   always @(posedge mclk) begin
      if (rst) begin
         line_meta <= {NCH{1'b0}};
         line_sync <= {NCH{1'b0}};
      end else begin
         line_meta <= int_line;
         line_sync <= line_meta;
      end
   end

   // index 0 is the top of the chain; each added group of
   // sixteen extends the chain downward, up to three groups so the 6-bit index can still return NCH
   assign top_pending = first_set(pending);
   assign top_service = first_set(in_service);
   assign top_pending_hot = onehot(top_pending);
   assign top_service_hot = onehot(top_service);
   assign any_pending = |pending;
   assign any_service = |in_service;

   // highest pending blocks all below it, even while in service
   assign next_request = any_pending && !(|(top_pending_hot & in_service));

   // exit pulse from an indirect unconditional branch
   assign exit_now = phase_zero && indirect_bit && (opcode == `PIL_OP_BRANCH) &&
                     in_window;
   // the window spans six cycles; clearing on each would walk down
   // up to six channels of the in-service chain, so only its first cycle clears
   assign exit_first = exit_now && !subroutine_exit_pulse;

   // acknowledge: flag set, not an end cycle, any time-share state
   assign ack_now = interrupt_flag && !end_cycle && in_window;

   assign flag_set = at_flag_time && end_cycle && request_to_processor;
   assign flag_clear = at_flag_time && interrupt_flag && !end_cycle;

   always @* begin
      next_pending = pending;
      next_in_service = in_service;
      // the exit clears only the top in-service channel
      if (exit_first && any_service) begin
         next_pending = next_pending & ~top_service_hot;
         next_in_service = next_in_service & ~top_service_hot;
      end
      // the line is latched only inside the pulse window; a new
      // request wins over the exit clear in the same cycle; stop_clear wins over both
      if (in_window)
         next_pending = next_pending | (line_sync & chan_mask);
      // whichever channel is top at acknowledge time is marked
      if (ack_now && any_pending)
         next_in_service = next_in_service | top_pending_hot;
      if (stop_clear) begin
         next_pending = {NCH{1'b0}};
         next_in_service = {NCH{1'b0}};
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         pending <= {NCH{1'b0}};
         in_service <= {NCH{1'b0}};
      end else begin
         pending <= next_pending;
         in_service <= next_in_service;
      end
   end

   // processor-side sequencing
   always @(posedge mclk) begin
      if (rst) begin
         request_to_processor <= 1'b0;
         interrupt_flag <= 1'b0;
         acknowledge_pulse <= 1'b0;
         subroutine_exit_pulse <= 1'b0;
         vector_address_lines <= 10'h000;
         load_vector <= 1'b0;
         suppress_p_transfer <= 1'b0;
         halt_clear <= 1'b0;
         enter_increment_phase <= 1'b0;
         req_prev <= 1'b0;
      end else begin
         request_to_processor <= next_request;
         req_prev <= request_to_processor;
         if (flag_set)
            interrupt_flag <= 1'b1;
         else if (flag_clear)
            interrupt_flag <= 1'b0;
         acknowledge_pulse <= ack_now;
         subroutine_exit_pulse <= exit_now;
         // vector follows the top pending channel, so a late
         // higher request still redirects the address load
         vector_address_lines <= VEC_BASE + {4'h0, top_pending};
         // flag replaces the counter transfer at T9
         load_vector <= interrupt_flag && at_load_time && !memory_share_cycle;
         suppress_p_transfer <= interrupt_flag && at_load_time && end_cycle;
         // only a halt from an instruction, switch at run
         halt_clear <= flag_set && halt_flag && run_switch_gate &&
                       !parity_error_flag;
         // a taken skip goes through the increment phase first
         enter_increment_phase <= flag_set && skip_taken;
      end
   end

   // event status: hardware set wins over software clear
   always @* begin
      next_evt_status = evt_status;
      if (reg_wr && reg_addr == `PIL_OFS_EVT_CLEAR)
         next_evt_status = next_evt_status & ~reg_wdata[`PIL_EVT_W-1:0];
      if (request_to_processor && !req_prev)
         next_evt_status[`PIL_EVT_REQ] = 1'b1;
      if (acknowledge_pulse)
         next_evt_status[`PIL_EVT_ACK] = 1'b1;
      if (subroutine_exit_pulse)
         next_evt_status[`PIL_EVT_EXIT] = 1'b1;
   end

   always @(posedge mclk) begin
      if (rst) begin
         evt_status <= {`PIL_EVT_W{1'b0}};
         evt_enable <= `PIL_RST_EVT_ENABLE;
         // all channels enabled; width follows the channel count
         chan_mask <= {NCH{1'b1}};
      end else begin
         evt_status <= next_evt_status;
         if (reg_wr && reg_addr == `PIL_OFS_EVT_ENABLE)
            evt_enable <= reg_wdata[`PIL_EVT_W-1:0];
         if (reg_wr && reg_addr == `PIL_OFS_MASK)
            chan_mask <= reg_wdata[NCH-1:0];
      end
   end

   assign irq = |(evt_status & evt_enable);

   // read data stand one cycle after the strobe, zero otherwise;
   // unmapped offsets read zero
   always @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `PIL_OFS_MASK: reg_rdata[NCH-1:0] <= chan_mask;
               `PIL_OFS_PENDING: reg_rdata[NCH-1:0] <= pending;
               `PIL_OFS_INSERV: reg_rdata[NCH-1:0] <= in_service;
               `PIL_OFS_EVT_STATUS: reg_rdata[`PIL_EVT_W-1:0] <= evt_status;
               `PIL_OFS_EVT_ENABLE: reg_rdata[`PIL_EVT_W-1:0] <= evt_enable;
               `PIL_OFS_VECTOR: reg_rdata[9:0] <= vector_address_lines;
               `PIL_OFS_FLAGS: begin
                  reg_rdata[`PIL_FLG_INT] <= interrupt_flag;
                  reg_rdata[`PIL_FLG_REQ] <= request_to_processor;
               end
               default: reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // pil_top

`default_nettype wire

/* tb/pil_seq.sv */
/* pulse counter model: steps T24 down to T0, one pulse a clock.
   assumes one mclk per pulse time. */
`timescale 1ns/1ps
`default_nettype none
module pil_seq (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // pulse number
   output logic [4:0] pulse_time
);
   // free-running: the machine cycle never pauses here
   always @(posedge mclk) begin
      if (rst || pulse_time == 5'h00) begin
         pulse_time <= 5'h18;
      end else begin
         pulse_time <= pulse_time - 5'h01;
      end
   end
endmodule // pil_seq
`default_nettype wire

/* tb/pil_top_chk.sv */
/* assertions on the priority interrupt controls.
   assumes binding into pil_top, clock mclk, synchronous rst. */
`timescale 1ns/1ps
`default_nettype none
module pil_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // sequencing
   input wire logic [4:0] pulse_time,
   input wire logic phase_bit_one,
   input wire logic phase_zero,
   input wire logic indirect_bit,
   input wire logic [5:0] opcode,
   input wire logic stop_clear,
   // controls
   input wire logic request_to_processor,
   input wire logic interrupt_flag,
   input wire logic acknowledge_pulse,
   input wire logic subroutine_exit_pulse,
   input wire logic load_vector,
   input wire logic suppress_p_transfer
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire win = pulse_time >= 5'h11 && pulse_time <= 5'h16;
   wire ack_why = interrupt_flag && !phase_bit_one && win;
   wire sup_why = interrupt_flag && phase_bit_one && pulse_time == 5'h09;
   wire exit_why = phase_zero && indirect_bit && opcode == 6'h01 && win;
   property p_flag_set;
      request_to_processor && phase_bit_one && pulse_time == 5'h0a |=> interrupt_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("no flag");
   property p_flag_clr;
      interrupt_flag && !phase_bit_one && pulse_time == 5'h0a |=> !interrupt_flag;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag kept");
   property p_req_win;
      $rose(request_to_processor) |-> $past(win, 2);
   endproperty
   a_req_win: assert property (p_req_win) else $error("late request");
   property p_ack;
      acknowledge_pulse |-> $past(ack_why);
   endproperty
   a_ack: assert property (p_ack) else $error("stray ack");
   property p_vec;
      load_vector |-> $past(interrupt_flag) && $past(pulse_time) == 5'h09;
   endproperty
   a_vec: assert property (p_vec) else $error("stray load");
   property p_sup;
      suppress_p_transfer |-> $past(sup_why);
   endproperty
   a_sup: assert property (p_sup) else $error("stray suppress");
   property p_exit;
      subroutine_exit_pulse |-> $past(exit_why);
   endproperty
   a_exit: assert property (p_exit) else $error("stray exit");
   property p_clear;
      stop_clear [*2] |=> !request_to_processor;
   endproperty
   a_clear: assert property (p_clear) else $error("request kept");
endmodule // pil_chk
bind pil_top pil_chk i_pil_chk (.mclk, .rst, .pulse_time, .phase_bit_one, .phase_zero,
   .indirect_bit, .opcode, .stop_clear, .request_to_processor, .interrupt_flag,
   .acknowledge_pulse, .subroutine_exit_pulse, .load_vector, .suppress_p_transfer);
`default_nettype wire

/* tb/pil_top_tb.sv */
/* bench of the priority interrupt logic.
   assumes pil_seq counts pulses; the bench plays the rest of the processor. */
`timescale 1ns/1ps
`default_nettype none
`include "pil_regs.vh"
module pil_top_tb;
   logic mclk = 1'b0, rst = 1'b1, e_c = 1'b0, ph0 = 1'b0, ind = 1'b0, sk = 1'b0;
   logic ts = 1'b0, halt = 1'b1, perr = 1'b0, run = 1'b1, stc = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [15:0] lines = 16'h0000;
   logic [5:0] op = 6'h00;
   logic [7:0] ra = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [5:0] saw;
   wire [4:0] pt;
   wire [31:0] rdata;
   wire [9:0] vec;
   wire req, flag, ack, ex, lv, sp, hc, eip, irq;
   int fails = 0, tests_run = 0, cycles = 0;
   always #12.5 mclk = ~mclk;
   pil_seq i_pil_seq (.mclk, .rst, .pulse_time(pt));
   pil_top i_pil_top (.mclk, .rst, .int_line(lines), .pulse_time(pt), .phase_bit_one(e_c),
      .phase_zero(ph0), .indirect_bit(ind), .opcode(op), .skip_taken(sk),
      .memory_share_cycle(ts), .halt_flag(halt), .parity_error_flag(perr),
      .run_switch_gate(run), .stop_clear(stc), .request_to_processor(req),
      .interrupt_flag(flag), .acknowledge_pulse(ack), .subroutine_exit_pulse(ex),
      .vector_address_lines(vec), .load_vector(lv), .suppress_p_transfer(sp),
      .halt_clear(hc), .enter_increment_phase(eip), .reg_addr(ra), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq);
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (fails == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      {ra, wd, wr} <= {a, d, 1'b1};
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rreg(input string n, input logic [7:0] a, input logic [31:0] exp);
      {ra, rd} <= {a, 1'b1};
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      chk(n, rdata, exp);
   endtask
   // one machine cycle; saw gathers {ex, eip, sp, lv, ack, hc}
   task automatic mcyc(input logic e, input logic b, input logic s);
      while (pt !== 5'h00) @(posedge mclk);
      {e_c, ph0, ind, sk} <= {e, b, b, s};
      op <= b ? `PIL_OP_BRANCH : 6'h00;
      saw = 6'h00;
      repeat (25) begin
         @(posedge mclk);
         saw = saw | {ex, eip, sp, lv, ack, hc};
      end
      {e_c, ph0, ind, sk} <= 4'h0;
   endtask
   task automatic single_channel;
      lines <= 16'h0002;
      mcyc(1'b0, 1'b0, 1'b0);
      chk("request", req, 1);
      mcyc(1'b1, 1'b0, 1'b0);
      chk("flag", flag, 1);
      chk("end pulses", saw, 6'h0d);
      chk("vector", vec, `PIL_VEC_BASE + 10'h001);
      mcyc(1'b0, 1'b0, 1'b0);
      chk("ack", saw[1], 1);
      chk("flag off", flag, 0);
      chk("request off", req, 0);
      rreg("in service", `PIL_OFS_INSERV, 32'h2);
      wreg(`PIL_OFS_EVT_ENABLE, 32'h0);
      chk("irq masked", irq, 0);
      wreg(`PIL_OFS_EVT_ENABLE, 32'h7);
      chk("irq", irq, 1);
      wreg(`PIL_OFS_EVT_CLEAR, 32'h7);
      chk("irq cleared", irq, 0);
   endtask
   task automatic nested_higher;
      lines <= 16'h0001;
      mcyc(1'b0, 1'b0, 1'b0);
      chk("nested request", req, 1);
      chk("top vector", vec, `PIL_VEC_BASE);
      mcyc(1'b1, 1'b0, 1'b1);
      chk("increment", saw[4], 1);
      lines <= 16'h0000;
      mcyc(1'b0, 1'b0, 1'b0);
      rreg("both served", `PIL_OFS_INSERV, 32'h3);
      mcyc(1'b0, 1'b1, 1'b0);
      chk("exit", saw[5], 1);
      rreg("high left", `PIL_OFS_INSERV, 32'h2);
      rreg("low kept", `PIL_OFS_PENDING, 32'h2);
      mcyc(1'b0, 1'b1, 1'b0);
      rreg("all left", `PIL_OFS_INSERV, 32'h0);
   endtask
   task automatic both_pending;
      lines <= 16'h0002;
      mcyc(1'b0, 1'b0, 1'b0);
      lines <= 16'h0003;
      mcyc(1'b1, 1'b0, 1'b0);
      chk("high vector", vec, `PIL_VEC_BASE);
      lines <= 16'h0000;
      mcyc(1'b0, 1'b0, 1'b0);
      rreg("high first", `PIL_OFS_INSERV, 32'h1);
      chk("low held", req, 0);
      mcyc(1'b0, 1'b1, 1'b0);
      chk("low resumes", req, 1);
   endtask
   task automatic stop_clear_all;
      stc <= 1'b1;
      repeat (3) @(posedge mclk);
      stc <= 1'b0;
      rreg("cleared", `PIL_OFS_PENDING, 32'h0);
   endtask
   task automatic shared_parity;
      lines <= 16'h0001;
      mcyc(1'b0, 1'b0, 1'b0);
      ts <= 1'b1;
      perr <= 1'b1;
      mcyc(1'b1, 1'b0, 1'b0);
      chk("shared end", saw, 6'h08);
      lines <= 16'h0000;
      mcyc(1'b0, 1'b0, 1'b0);
      chk("shared ack", saw[1], 1);
      rreg("shared served", `PIL_OFS_INSERV, 32'h1);
      ts <= 1'b0;
      perr <= 1'b0;
      mcyc(1'b0, 1'b1, 1'b0);
      rreg("shared left", `PIL_OFS_INSERV, 32'h0);
   endtask
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fails++;
         give_verdict;
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rreg("mask", `PIL_OFS_MASK, 32'h0000ffff);
      rreg("unmapped", 8'h20, 32'h0);
      wreg(`PIL_OFS_EVT_ENABLE, 32'h7);
      single_channel;
      nested_higher;
      both_pending;
      stop_clear_all;
      shared_parity;
      give_verdict;
   end
endmodule // pil_top_tb
`default_nettype wire
